// ### logic/fil_pkg.sv
// Package of constants and types for the fault interrupt logic.
// Functional notes
// RULE1 - Over-temperature trip: standby and overheat flag set.
// RULE2 - Host restarts by clearing standby after cooling.
// RULE3 - Cooling below release point raises no flag.
// RULE4 - Clearing overheat flag while hot sets it again.
// RULE5 - Five sources, each flag and enable bit.
// RULE6 - Main light flag on any threshold change.
// RULE7 - Second light flag likewise from second sensor.
// RULE8 - Overvoltage flag set at each overvoltage instance.
// RULE9 - Short flag set on entering short protection.
// RULE10 - Only enabled flags reach the interrupt pin.
// RULE11 - Writing one clears flag; reset clears all.
// RULE12 - Reading or writing zero leaves flags unchanged.
// RULE13 - Host disables unused sinks in documented order.
// RULE14 - Reset or undervoltage restores register defaults.
// RULE15 - Flags live in register index two.
// RULE16 - Interrupt pin is active-low open drain.
package fil_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int ADDR_W = 8;   // Byte address width of the slave.
  localparam int DATA_W = 32;  // Bus data width.
  localparam int IDX_LSB = 2;  // Byte address is four times the register index.
  localparam int IDX_W = ADDR_W - IDX_LSB;  // Width of a register index.

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address is index times four).
  localparam logic [IDX_W-1:0] CTRL_IDX = 6'h01;  // Mode register with run bit.
  localparam logic [IDX_W-1:0] FLAG_IDX = 6'h02;  // Sticky fault flags.
  localparam logic [IDX_W-1:0] IEN_IDX  = 6'h03;  // Interrupt enables.

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values.
  localparam int NUM_SRC = 5;   // Number of interrupt sources.
  localparam int RUN_BIT = 5;   // Run bit, low means standby.
  localparam logic [NUM_SRC-1:0] FLAG_RST = 5'h00;  // Flags after reset.
  localparam logic [NUM_SRC-1:0] IEN_RST  = 5'h00;  // Enables after reset.
  localparam logic RUN_RST = 1'h0;                  // Device starts in standby.

  ////////////////////////////////////////////////////////////////////////////
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Access done.
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address.

  ////////////////////////////////////////////////////////////////////////////
  // Flag layout, shared by the flag and enable registers, bit 4 down to 0.
  typedef struct packed {
    logic short_flag;        // Short-circuit protection entered.
    logic overheat_flag;     // Thermal shutdown entered.
    logic overvoltage_flag;  // Output overvoltage seen.
    logic light_cmp2_flag;   // Second sensor crossed a threshold.
    logic light_cmp_flag;    // Main sensor crossed a threshold.
  } fil_evt_t;

  // Comparator outputs of one light sensor.
  typedef struct packed {
    logic dark_level;    // Below the dark threshold.
    logic office_level;  // Below the office threshold.
  } fil_light_t;

endpackage

// ### logic/fil_sticky_flag.sv
// Bank of sticky flags in which a set beats a clear in the same cycle.
`timescale 1ns/1ps
module fil_sticky_flag #(
  parameter int WIDTH = 5
) (
  // Clock and resets.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear_all,
  // Per-bit events and clears.
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // Stored flags.
  output logic      [WIDTH-1:0] flag
);

  // A set arriving with its clear is kept, so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_all) begin
      flag <= '0;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule

// ### logic/fil_top.sv
// Fault interrupt controller with thermal shutdown and an AXI4-Lite slave.
`timescale 1ns/1ps
module fil_top (
  // Clock and reset.
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Device-level resets.
  input  wire logic                        external_reset_n,
  input  wire logic                        uvlo_event,
  // Fault and sensor inputs.
  input  wire logic                        over_temp_trip,
  input  wire logic                        die_above_release,
  input  wire fil_pkg::fil_light_t         main_light,
  input  wire fil_pkg::fil_light_t         second_light,
  input  wire logic                        overvoltage_protect,
  input  wire logic                        short_protect,
  // AXI4-Lite write address and data.
  input  wire logic [fil_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [fil_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // AXI4-Lite write response.
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // AXI4-Lite read channels.
  input  wire logic [fil_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [fil_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Device state.
  output logic                             standby,
  output logic                             thermal_shutdown,
  // Interrupt as a level and as an open-drain pin.
  output logic                             irq,
  output logic                             interrupt_out_n_o,
  output logic                             interrupt_out_n_oe
);
  import fil_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic             dev_rst;          // Pin reset or undervoltage, synchronous.
  logic             run_reg;          // Run bit; low holds standby.
  logic             tsd_reg;          // Thermal shutdown state.
  logic             tsd_enter;        // Entry into thermal shutdown.
  fil_evt_t         flags;            // Sticky flags.
  fil_evt_t         ien_reg;          // Interrupt enables.
  fil_evt_t         set_vec;          // Events of this cycle.
  fil_evt_t         clr_vec;          // Clears written by software.
  fil_light_t       main_prev;        // Main sensor result last cycle.
  fil_light_t       second_prev;      // Second sensor result last cycle.
  logic             light_armed;      // Previous results are valid.
  logic             ovp_prev;         // Overvoltage input last cycle.
  logic             short_prev;       // Short input last cycle.
  logic             aw_held;          // Write address captured.
  logic [IDX_W-1:0] aw_idx;           // Captured write index.
  logic             w_held;           // Write data captured.
  logic [7:0]       wbyte;            // Captured low data byte.
  logic             wlane0;           // Captured strobe of the low byte.
  logic             do_write;         // Both halves held, response free.
  logic             wr_hit;           // Write index is mapped.
  logic [IDX_W-1:0] ar_idx;           // Read index.
  logic [DATA_W-1:0] rd_word;         // Read data before the flop.
  logic             rd_hit;           // Read index is mapped.

  // Read index; the two byte bits below a word are ignored.
  assign ar_idx  = araddr[ADDR_W-1:IDX_LSB];
  // Pin reset and undervoltage act alike, but leave the bus logic alone.
  assign dev_rst = !external_reset_n || uvlo_event;  // RULE14
  // A write lands only once both halves are held and the last answer is gone.
  assign do_write = aw_held && w_held && !bvalid;
  // Unmapped writes get an error response and change nothing.
  assign wr_hit  = (aw_idx == CTRL_IDX) || (aw_idx == FLAG_IDX) || (aw_idx == IEN_IDX);

  ////////////////////////////////////////////////////////////////////////////
  // Thermal shutdown.

  // Entry is the first cycle of a trip; a trip already latched is not news.
  assign tsd_enter = over_temp_trip && !tsd_reg;

  // The state holds until the die is below the release point, so the host
  // cannot restart a part that is still hot.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst) begin
      tsd_reg <= 1'b0;
    end else if (over_temp_trip) begin
      tsd_reg <= 1'b1;  // RULE1
    end else if (!die_above_release) begin
      tsd_reg <= 1'b0;  // RULE3
    end
  end

  // Run bit: hardware drops it on shutdown; a host write of one only takes
  // effect once the part has cooled.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst) begin
      run_reg <= RUN_RST;  // RULE14
    end else if (tsd_enter || tsd_reg) begin
      run_reg <= 1'b0;  // RULE1
    end else if (do_write && wlane0 && aw_idx == CTRL_IDX) begin
      run_reg <= wbyte[RUN_BIT];  // RULE2
    end
  end

  assign standby = !run_reg;
  assign thermal_shutdown = tsd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Event detection.

  // Edge history; the arm bit stops the first sample after reset from
  // looking like a threshold crossing.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst) begin
      main_prev   <= '0;
      second_prev <= '0;
      light_armed <= 1'b0;
      ovp_prev    <= 1'b0;
      short_prev  <= 1'b0;
    end else begin
      main_prev   <= main_light;
      second_prev <= second_light;
      light_armed <= 1'b1;
      ovp_prev    <= overvoltage_protect;
      short_prev  <= short_protect;
    end
  end

  // Software clears: a one in the low byte of a flag write, nothing else.
  always_comb begin
    clr_vec = '0;
    if (do_write && wlane0 && aw_idx == FLAG_IDX) begin
      clr_vec = fil_evt_t'(wbyte[NUM_SRC-1:0]);  // RULE11 RULE12
    end
  end

  // Events of this cycle.
  always_comb begin
    set_vec = '0;
    set_vec.light_cmp_flag   = light_armed && (main_light != main_prev);  // RULE6
    set_vec.light_cmp2_flag  = light_armed && (second_light != second_prev);  // RULE7
    set_vec.overvoltage_flag = overvoltage_protect && !ovp_prev;  // RULE8
    set_vec.short_flag       = short_protect && !short_prev;  // RULE9
    // Entry, or a clear while still hot, which re-raises the flag.
    set_vec.overheat_flag = tsd_enter  // RULE1
                         || (clr_vec.overheat_flag && die_above_release);  // RULE4
  end

  // Five independent sticky flags.
  fil_sticky_flag #(
    .WIDTH(NUM_SRC)
  ) u_flags (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear_all(dev_rst),
    .set      (set_vec),
    .clr      (clr_vec),
    .flag     (flags)
  );  // RULE5 RULE11 RULE14

  ////////////////////////////////////////////////////////////////////////////
  // Enable register and interrupt pin.

  // Enables steer which flags reach the pin.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst) begin
      ien_reg <= IEN_RST;  // RULE14
    end else if (do_write && wlane0 && aw_idx == IEN_IDX) begin
      ien_reg <= fil_evt_t'(wbyte[NUM_SRC-1:0]);
    end
  end

  // The pin is pulled low only; the board pull-up provides the high level.
  assign irq = |(flags & ien_reg);  // RULE10
  assign interrupt_out_n_o  = 1'b0;  // RULE16
  assign interrupt_out_n_oe = irq;  // RULE16

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  // Address and data are captured independently, in either order.
  assign awready = !aw_held;
  assign wready  = !w_held;

  // Write address holder.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx  <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_idx  <= awaddr[ADDR_W-1:IDX_LSB];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data holder; registers are eight bits wide in the low lane.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wbyte  <= '0;
      wlane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wbyte  <= wdata[7:0];
      wlane0 <= wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Response one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  // Reads have no side effect, so flags survive polling.
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (ar_idx)
      CTRL_IDX: rd_word[RUN_BIT] = run_reg;
      FLAG_IDX: rd_word[NUM_SRC-1:0] = flags;  // RULE15 RULE12
      IEN_IDX:  rd_word[NUM_SRC-1:0] = ien_reg;
      default:  rd_hit = 1'b0;
    endcase
  end

  assign arready = !rvalid;

  // Read data and response come from flops the cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_tsd_entry: assert property (  // RULE1
    tsd_enter && !dev_rst |=> standby && flags.overheat_flag && tsd_reg)
    else $error("thermal trip did not force standby and flag");

  a_restart_cool: assert property (  // RULE2
    do_write && wlane0 && aw_idx == CTRL_IDX && wbyte[RUN_BIT] && !tsd_reg
    && !over_temp_trip && !dev_rst |=> !standby)
    else $error("restart after cooling ignored");

  a_hot_restart: assert property (  // RULE2
    tsd_reg && over_temp_trip |=> standby)
    else $error("part left standby while hot");

  // Cooling out of shutdown must never raise the flag, whatever it held.
  a_cool_silent: assert property (  // RULE3
    tsd_reg && !over_temp_trip && !die_above_release && !dev_rst
    |=> !$rose(flags.overheat_flag))
    else $error("flag raised on cooling");

  a_hot_reraise: assert property (  // RULE4
    flags.overheat_flag && clr_vec.overheat_flag && die_above_release
    && !dev_rst |=> flags.overheat_flag [*1] ##0 !$fell(flags.overheat_flag))
    else $error("overheat flag cleared while hot");

  a_light_edge: assert property (  // RULE6
    light_armed && main_light != main_prev && !dev_rst |=> flags.light_cmp_flag)
    else $error("main light change lost");

  a_light2_edge: assert property (  // RULE7
    light_armed && second_light != second_prev && !dev_rst
    |=> flags.light_cmp2_flag)
    else $error("second light change lost");

  a_ovp_flag: assert property (  // RULE8
    overvoltage_protect && !ovp_prev && !dev_rst |=> flags.overvoltage_flag)
    else $error("overvoltage instance lost");

  a_short_flag: assert property (  // RULE9
    short_protect && !short_prev && !dev_rst |=> flags.short_flag)
    else $error("short protection entry lost");

  a_irq_gate: assert property (  // RULE10
    (flags & ien_reg) == '0 |-> !interrupt_out_n_oe && !irq)
    else $error("masked flag reached pin");

  a_irq_drive: assert property (  // RULE16
    $rose(flags.short_flag) && ien_reg.short_flag |-> interrupt_out_n_oe
    && !interrupt_out_n_o)
    else $error("enabled flag did not pull pin low");

  a_clear_one: assert property (  // RULE11
    clr_vec.short_flag && !set_vec.short_flag && !dev_rst |=> !flags.short_flag)
    else $error("write of one did not clear");

  a_read_keep: assert property (  // RULE12
    arvalid && arready && flags.light_cmp_flag && !clr_vec.light_cmp_flag
    && !dev_rst |=> flags.light_cmp_flag)
    else $error("read changed a flag");

  a_dev_reset: assert property (  // RULE14
    dev_rst |=> flags == '0 && ien_reg == '0 && standby && !tsd_reg)
    else $error("device reset left state");

  a_write_resp: assert property (
    do_write |=> bvalid ##0 (bresp == (($past(wr_hit)) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response wrong");

  c_tsd_entry: cover property (tsd_enter ##1 standby);
  c_reraise: cover property (clr_vec.overheat_flag && die_above_release);
  c_irq_pin: cover property ($rose(interrupt_out_n_oe));
  c_flag_read: cover property (arvalid && arready && ar_idx == FLAG_IDX);

endmodule

// ### dv/fil_host_model.sv
// Host model: AXI4-Lite master tasks and the pulled-up interrupt line.
`timescale 1ns/1ps
module fil_host_model (
  // Clock.
  input  wire logic                        aclk,
  // Write channels.
  output logic [fil_pkg::ADDR_W-1:0]       awaddr,
  output logic                             awvalid,
  input  wire logic                        awready,
  output logic [fil_pkg::DATA_W-1:0]       wdata,
  output logic [3:0]                       wstrb,
  output logic                             wvalid,
  input  wire logic                        wready,
  input  wire logic [1:0]                  bresp,
  input  wire logic                        bvalid,
  output logic                             bready,
  // Read channels.
  output logic [fil_pkg::ADDR_W-1:0]       araddr,
  output logic                             arvalid,
  input  wire logic                        arready,
  input  wire logic [fil_pkg::DATA_W-1:0]  rdata,
  input  wire logic [1:0]                  rresp,
  input  wire logic                        rvalid,
  output logic                             rready,
  // Open-drain pin as seen by the host.
  input  wire logic                        interrupt_out_n_o,
  input  wire logic                        interrupt_out_n_oe,
  output logic                             interrupt_out_n
);
  ////////////////////////////////////////////////////////////////////////////
  // The host board holds a pull-up, so a released pin reads high.
  assign interrupt_out_n = interrupt_out_n_oe ? interrupt_out_n_o : 1'b1;

  // Idle bus at time zero.
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One write; handshakes are judged in the low half, where all is settled.
  // Flag clears are write-one; sink shutdown is two writes in order.
  // A write with no byte strobe set must change nothing.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] s = 4'hF);
    logic ah;
    logic wh;
    logic bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end while (!bh);
  endtask

  // One read; the data are taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah;
    logic vh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready;
      vh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (vh) rready <= 1'b0;
    end while (!vh);
  endtask
endmodule

// ### dv/tb.sv
// Self-checking testbench for the fault interrupt controller.
`timescale 1ns/1ps
module tb;
  import fil_pkg::*;
  logic              aclk, aresetn, external_reset_n, uvlo_event;
  logic              over_temp_trip, die_above_release, overvoltage_protect, short_protect;
  fil_light_t        main_light, second_light;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic              standby, thermal_shutdown, irq;
  logic              interrupt_out_n_o, interrupt_out_n_oe, interrupt_out_n;
  logic [4:0]        en, e;
  int                n_fail, tests_run;
  int                pos[4] = '{0, 1, 2, 4};  // Flag bit of each event kind.

  fil_top fil_top_i (.*);
  fil_host_model fil_host_model_i (.*);

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Compare and count; an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Register read with comparison of data and response.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    fil_host_model_i.rd(a, d, r);
    chk(d, exp, m);
    chk(32'(r), 32'(RESP_OKAY), "read response");
  endtask

  // Expected level of the interrupt from flags and enables.
  function automatic logic exp_irq(input logic [4:0] f, input logic [4:0] m);
    return |(f & m);
  endfunction

  // Closing task: counts, then the verdict.
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs under a thousand cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {aresetn, uvlo_event, over_temp_trip, die_above_release} = '0;
    {overvoltage_protect, short_protect, main_light, second_light} = '0;
    external_reset_n = 1'b1;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(32'h79C060E2));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Defaults after reset.
    rchk(8'h08, 32'h0, "flags at reset");
    rchk(8'h0C, 32'h0, "enables at reset");
    chk(32'(standby), 32'h1, "standby at reset");
    chk(32'(interrupt_out_n), 32'h1, "pin released");
    $display("Test reset defaults done");
    // Sink shutdown order touches unmapped places in this block.
    fil_host_model_i.wr(8'h14, 32'h7F, r);
    chk(32'(r), 32'(RESP_SLVERR), "sink select");
    fil_host_model_i.wr(8'h40, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR), "sink enable");
    fil_host_model_i.rd(8'h00, d, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    $display("Test unmapped done");
    // Light, second light, overvoltage and short events in turn with a random enable mask.
    for (int i = 0; i < 16; i++) begin
      en = 5'($urandom);
      e = 5'(1 << pos[i % 4]);
      fil_host_model_i.wr(8'h0C, 32'(en), r);
      chk(32'(r), 32'(RESP_OKAY), "enable write response");
      fil_host_model_i.wr(8'h08, 32'h1F, r);
      @(posedge aclk);
      case (i % 4)
        0: main_light <= main_light ^ 2'($urandom_range(1, 3));
        1: second_light <= second_light ^ 2'($urandom_range(1, 3));
        2: overvoltage_protect <= 1'b1;
        default: short_protect <= 1'b1;
      endcase
      @(posedge aclk);
      overvoltage_protect <= 1'b0;
      short_protect <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'(exp_irq(e, en)), "irq level");
      chk(32'(interrupt_out_n), 32'(!exp_irq(e, en)), "pin level");
      rchk(8'h0C, 32'(en), "enable readback");
      rchk(8'h08, 32'(e), "event flag");
      fil_host_model_i.wr(8'h08, 32'h0, r);
      rchk(8'h08, 32'(e), "flag after read and zero write");
      fil_host_model_i.wr(8'h08, 32'(e), r, 4'h0);
      rchk(8'h08, 32'(e), "flag kept without lane strobe");
      fil_host_model_i.wr(8'h08, 32'(e), r);
      rchk(8'h08, 32'h0, "flag cleared by one");
    end
    $display("Test events done");
    // Thermal shutdown while running.
    fil_host_model_i.wr(8'h04, 32'h20, r);
    chk(32'(standby), 32'h0, "running");
    fil_host_model_i.wr(8'h0C, 32'h08, r);
    @(posedge aclk);
    over_temp_trip <= 1'b1;
    die_above_release <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'(standby), 32'h1, "standby on trip");
    chk(32'(thermal_shutdown), 32'h1, "shutdown on trip");
    chk(32'(interrupt_out_n), 32'h0, "pin pulled low");
    over_temp_trip <= 1'b0;
    fil_host_model_i.wr(8'h08, 32'h08, r);
    rchk(8'h08, 32'h08, "overheat set again");
    fil_host_model_i.wr(8'h04, 32'h20, r);
    chk(32'(standby), 32'h1, "restart while hot");
    die_above_release <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(thermal_shutdown), 32'h0, "cooled");
    fil_host_model_i.wr(8'h08, 32'h08, r);
    repeat (3) @(posedge aclk);
    rchk(8'h08, 32'h0, "no flag on cooling");
    fil_host_model_i.wr(8'h04, 32'h20, r);
    chk(32'(standby), 32'h0, "restart when cool");
    $display("Test thermal done");
    // Device reset pin and undervoltage both restore defaults.
    for (int j = 0; j < 2; j++) begin
      fil_host_model_i.wr(8'h0C, 32'h1F, r);
      @(posedge aclk);
      main_light <= ~main_light;
      repeat (2) @(posedge aclk);
      if (j == 0) external_reset_n <= 1'b0;
      else uvlo_event <= 1'b1;
      @(posedge aclk);
      external_reset_n <= 1'b1;
      uvlo_event <= 1'b0;
      @(posedge aclk);
      rchk(8'h08, 32'h0, "flags after device reset");
      rchk(8'h0C, 32'h0, "enables after device reset");
      chk(32'(standby), 32'h1, "standby after device reset");
      chk(32'(interrupt_out_n), 32'h1, "pin released after device reset");
    end
    $display("Test device reset done");
    give_verdict();
  end
endmodule
